// File: rtl/pgw_pkg.sv
// Constants and types of the planar graphics write/read datapath
package pgw_pkg;
   localparam int          PGW_PLANES      = 4;
   localparam int          PGW_BYTE_W      = 8;
   localparam int          PGW_BUS_W       = PGW_PLANES * PGW_BYTE_W;
   localparam int          PGW_IDX_W       = 4;
   localparam int          PGW_NREG        = 9;
   // I/O port addresses
   localparam logic [15:0] PGW_INDEX_PORT  = 16'h03CE;
   localparam logic [15:0] PGW_DATA_PORT   = 16'h03CF;
   // Register indices
   localparam logic [3:0]  PGW_IDX_FILL    = 4'h0;
   localparam logic [3:0]  PGW_IDX_FILL_EN = 4'h1;
   localparam logic [3:0]  PGW_IDX_CMP     = 4'h2;
   localparam logic [3:0]  PGW_IDX_ROT     = 4'h3;
   localparam logic [3:0]  PGW_IDX_RSEL    = 4'h4;
   localparam logic [3:0]  PGW_IDX_MODE    = 4'h5;
   localparam logic [3:0]  PGW_IDX_MODE2   = 4'h6;
   localparam logic [3:0]  PGW_IDX_DCARE   = 4'h7;
   localparam logic [3:0]  PGW_IDX_WMASK   = 4'h8;
   // Field positions
   localparam int          PGW_ROT_LSB     = 0;
   localparam int          PGW_ROT_W       = 3;
   localparam int          PGW_FUNC_LSB    = 3;
   localparam int          PGW_RSEL_LSB    = 0;
   localparam int          PGW_RSEL_NONE   = 2;
   localparam int          PGW_WM_LSB      = 0;
   localparam int          PGW_RDMODE_BIT  = 3;
   localparam int          PGW_SHFMT_BIT   = 5;
   // Values
   localparam logic [7:0]  PGW_REG_RESET   = 8'h00;
   localparam logic [7:0]  PGW_ONES        = 8'hFF;
   localparam logic [7:0]  PGW_ZEROS       = 8'h00;

   typedef enum logic [1:0] {
      PGW_FN_REPLACE = 2'h0,
      PGW_FN_AND     = 2'h1,
      PGW_FN_OR      = 2'h2,
      PGW_FN_XOR     = 2'h3
   } pgw_func_t;

   typedef enum logic [1:0] {
      PGW_WM_FILL    = 2'h0,
      PGW_WM_LATCH   = 2'h1,
      PGW_WM_EXPAND  = 2'h2,
      PGW_WM_ILLEGAL = 2'h3
   } pgw_wmode_t;
endpackage

// File: rtl/pgw_ser_if.sv
// Interface between datapath and serializer shift registers
`timescale 1ns/10ps
`default_nettype none
interface pgw_ser_if;
   import pgw_pkg::*;
   logic                 load;
   logic                 shift;
   logic                 format;
   logic [PGW_BUS_W-1:0] data;
   logic [PGW_PLANES-1:0] serial;
   modport ctrl (output load, output shift, output format, output data,
                 input serial);
   modport ser  (input load, input shift, input format, input data,
                 output serial);
endinterface
`default_nettype wire

// File: rtl/pgw_serializer.sv
// Four serializer shift registers with normal or even/odd format
`timescale 1ns/10ps
`default_nettype none
module pgw_serializer
   import pgw_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset,
   pgw_ser_if.ser    sif
);
   genvar p, k;
   generate
      for (p = 0; p < PGW_PLANES; p++) begin : g_lane
         logic [PGW_BYTE_W-1:0] sr;
         logic [PGW_BYTE_W-1:0] next_sr;
         logic [PGW_BYTE_W-1:0] fmt_val;
         localparam int BASE = (p / 2) * 2;
         localparam int PAR  = p % 2;
         // Even bits to even lanes, odd bits to odd lanes, pair of planes
         for (k = 0; k < PGW_PLANES; k++) begin : g_bit
            assign fmt_val[PGW_BYTE_W-1-k] =
               sif.data[BASE*PGW_BYTE_W + 6 + PAR - 2*k];
            assign fmt_val[PGW_PLANES-1-k] =
               sif.data[(BASE+1)*PGW_BYTE_W + 6 + PAR - 2*k];
         end
         always_comb begin
            next_sr = sr;
            if (sif.load) begin
               if (sif.format) begin
                  next_sr = fmt_val;
               end else begin
                  next_sr = sif.data[p*PGW_BYTE_W +: PGW_BYTE_W];
               end
            end else if (sif.shift) begin
               next_sr = {sr[PGW_BYTE_W-2:0], 1'b0};
            end
         end
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               sr <= PGW_ZEROS;
            end else begin
               sr <= next_sr;
            end
         end
         assign sif.serial[p] = sr[PGW_BYTE_W-1];
      end
   endgenerate

   chk_normal_load: assert property (
      @(posedge sys_clk) disable iff (reset)
      (sif.load && !sif.format) |=> sif.serial[0] == $past(sif.data[7]))
      else $error("normal load does not present plane 0 msb");
endmodule
`default_nettype wire

// File: rtl/pgw_graphics_datapath.sv
// Graphics controller datapath: indexed registers, write ALU, read paths
//
// How it works
// - Four-bit index picks data-port register
// - Data registers are write only
// - Mode zero fills colour where data ones
// - Data bit n is pixel seven minus n
// - Fill-disabled plane takes rotated CPU data through function
// - Read-mode bit returns colour compare result
// - Compare bit set where four planes match
// - Don't-care planes excluded from comparison
// - Function field: replace, AND, OR, XOR
// - Logical ops combine latch with CPU data
// - Mode zero rotates CPU data right
// - Read-select field chooses returned plane
// - Read-select bit two set selects nothing
// - Normal format shifts planes MSB first
// - Even/odd format splits bits across registers
// - Plane-select register drives non-compare reads
// - Mode one writes latched read data
// - Mode two expands data bits to planes
// - Only write-enabled planes are modified
// - Write mask protects bits via read-before-write
`timescale 1ns/10ps
`default_nettype none
module pgw_graphics_datapath
   import pgw_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic [15:0]           io_addr,
   input  wire logic                  io_wr,
   input  wire logic [7:0]            io_wdata,
   input  wire logic                  mem_rd_req,
   input  wire logic                  mem_wr_req,
   input  wire logic [7:0]            cpu_wdata,
   input  wire logic [PGW_BUS_W-1:0]  plane_rdata,
   input  wire logic [PGW_PLANES-1:0] plane_write_enable,
   input  wire logic                  ser_load,
   input  wire logic                  ser_shift,
   input  wire logic [PGW_BUS_W-1:0]  disp_data,
   output logic [7:0]                 cpu_rdata,
   output logic                       cpu_rdata_valid,
   output logic [PGW_BUS_W-1:0]       plane_wdata,
   output logic [PGW_PLANES-1:0]      plane_we,
   output logic [PGW_PLANES-1:0]      ser_out
);
   // Register file
   logic [PGW_IDX_W-1:0]  index_ptr;
   logic [PGW_IDX_W-1:0]  next_index_ptr;
   logic [7:0]            gc_reg      [PGW_NREG];
   logic [7:0]            next_gc_reg [PGW_NREG];
   logic                  idx_wr;
   logic                  data_wr;

   assign idx_wr  = io_wr && (io_addr == PGW_INDEX_PORT);
   assign data_wr = io_wr && (io_addr == PGW_DATA_PORT);

   // No read path exists for the register ports
   always_comb begin
      next_index_ptr = index_ptr;
      for (int i = 0; i < PGW_NREG; i++) begin
         next_gc_reg[i] = gc_reg[i];
      end
      if (idx_wr) begin
         next_index_ptr = io_wdata[PGW_IDX_W-1:0];
      end
      if (data_wr && (index_ptr <= PGW_IDX_WMASK)
          && (index_ptr != PGW_IDX_MODE2)) begin
         next_gc_reg[index_ptr] = io_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         index_ptr <= PGW_IDX_W'(PGW_REG_RESET);
         for (int i = 0; i < PGW_NREG; i++) begin
            gc_reg[i] <= PGW_REG_RESET;
         end
      end else begin
         index_ptr <= next_index_ptr;
         for (int i = 0; i < PGW_NREG; i++) begin
            gc_reg[i] <= next_gc_reg[i];
         end
      end
   end

   // Field decode
   logic [PGW_PLANES-1:0] fill_val;
   logic [PGW_PLANES-1:0] fill_en;
   logic [PGW_PLANES-1:0] cmp_col;
   logic [PGW_PLANES-1:0] dont_care;
   logic [PGW_ROT_W-1:0]  rot_cnt;
   pgw_func_t             func_sel;
   pgw_wmode_t            wmode;
   logic [2:0]            rsel;
   logic                  read_cmp;
   logic [7:0]            wmask;

   assign fill_val  = gc_reg[PGW_IDX_FILL][PGW_PLANES-1:0];
   assign fill_en   = gc_reg[PGW_IDX_FILL_EN][PGW_PLANES-1:0];
   assign cmp_col   = gc_reg[PGW_IDX_CMP][PGW_PLANES-1:0];
   assign dont_care = gc_reg[PGW_IDX_DCARE][PGW_PLANES-1:0];
   assign rot_cnt   = gc_reg[PGW_IDX_ROT][PGW_ROT_LSB +: PGW_ROT_W];
   assign func_sel  = pgw_func_t'(gc_reg[PGW_IDX_ROT][PGW_FUNC_LSB +: 2]);
   assign wmode     = pgw_wmode_t'(gc_reg[PGW_IDX_MODE][PGW_WM_LSB +: 2]);
   assign rsel      = gc_reg[PGW_IDX_RSEL][PGW_RSEL_LSB +: 3];
   assign read_cmp  = gc_reg[PGW_IDX_MODE][PGW_RDMODE_BIT];
   assign wmask     = gc_reg[PGW_IDX_WMASK];

   // Logical merge of source data with latched plane data
   function automatic logic [7:0] pgw_alu(input pgw_func_t fn,
                                          input logic [7:0] d,
                                          input logic [7:0] l);
      logic [7:0] r;
      r = d;
      case (fn)
         PGW_FN_REPLACE: r = d;
         PGW_FN_AND:     r = d & l;
         PGW_FN_OR:      r = d | l;
         PGW_FN_XOR:     r = d ^ l;
         default:        r = d;
      endcase
      return r;
   endfunction

   // Plane latches, reloaded on each CPU memory read (mem_rd_req)
   logic [PGW_BUS_W-1:0] latch;
   logic [PGW_BUS_W-1:0] next_latch;
   logic                 do_write;

   // A read and a write in the same cycle: the read is served
   assign do_write = mem_wr_req && !mem_rd_req;

   // End-around rotate right, low bits wrap into high bits
   logic [15:0] rot_wide;
   logic [7:0]  rot_data;
   assign rot_wide = {cpu_wdata, cpu_wdata} >> rot_cnt;
   assign rot_data = rot_wide[7:0];

   // Per-plane write data with mask protection
   logic [PGW_BUS_W-1:0]  merged;
   logic [PGW_BUS_W-1:0]  next_plane_wdata;
   logic [PGW_PLANES-1:0] next_plane_we;
   logic [PGW_PLANES-1:0] pix     [PGW_BYTE_W];
   logic [7:0]            cmp_hit;

   genvar p, b;
   generate
      for (p = 0; p < PGW_PLANES; p++) begin : g_plane
         logic [7:0] lat;
         logic [7:0] old;
         logic [7:0] val;
         logic [7:0] bmask;
         logic [7:0] keep;
         assign lat = latch[p*PGW_BYTE_W +: PGW_BYTE_W];
         assign old = plane_rdata[p*PGW_BYTE_W +: PGW_BYTE_W];
         always_comb begin
            val   = old;
            bmask = PGW_ZEROS;
            case (wmode)
               PGW_WM_FILL: begin
                  if (fill_en[p]) begin
                     val   = {PGW_BYTE_W{fill_val[p]}};
                     bmask = rot_data;
                  end else begin
                     val   = pgw_alu(func_sel, rot_data, lat);
                     bmask = PGW_ONES;
                  end
               end
               PGW_WM_LATCH: begin
                  val   = lat;
                  bmask = PGW_ONES;
               end
               PGW_WM_EXPAND: begin
                  val   = pgw_alu(func_sel,
                                  {PGW_BYTE_W{cpu_wdata[p]}}, lat);
                  bmask = PGW_ONES;
               end
               // Illegal mode writes nothing new
               default: begin
                  val   = old;
                  bmask = PGW_ZEROS;
               end
            endcase
         end
         // Protected bits are taken back from the read-before-write data
         assign keep = ~(bmask & wmask);
         assign merged[p*PGW_BYTE_W +: PGW_BYTE_W] =
            (val & ~keep) | (old & keep);
      end

      // Colour compare, one result bit per pixel
      for (b = 0; b < PGW_BYTE_W; b++) begin : g_pix
         for (p = 0; p < PGW_PLANES; p++) begin : g_pl
            assign pix[b][p] = plane_rdata[p*PGW_BYTE_W + b];
         end
         assign cmp_hit[b] = &((pix[b] ~^ cmp_col) | dont_care);
      end
   endgenerate

   // Read return
   logic [7:0] sel_byte;
   logic [7:0] next_cpu_rdata;
   logic       next_cpu_rdata_valid;

   always_comb begin
      sel_byte = PGW_ZEROS;
      if (!rsel[PGW_RSEL_NONE]) begin
         sel_byte = plane_rdata[rsel[1:0]*PGW_BYTE_W +: PGW_BYTE_W];
      end
   end

   always_comb begin
      next_latch           = latch;
      next_cpu_rdata       = cpu_rdata;
      next_cpu_rdata_valid = mem_rd_req;
      next_plane_wdata     = plane_wdata;
      next_plane_we        = '0;
      if (mem_rd_req) begin
         next_latch = plane_rdata;
         if (read_cmp) begin
            next_cpu_rdata = cmp_hit;
         end else begin
            next_cpu_rdata = sel_byte;
         end
      end
      if (do_write) begin
         next_plane_wdata = merged;
         next_plane_we    = plane_write_enable;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch           <= '0;
         cpu_rdata       <= PGW_ZEROS;
         cpu_rdata_valid <= 1'b0;
         plane_wdata     <= '0;
         plane_we        <= '0;
      end else begin
         latch           <= next_latch;
         cpu_rdata       <= next_cpu_rdata;
         cpu_rdata_valid <= next_cpu_rdata_valid;
         plane_wdata     <= next_plane_wdata;
         plane_we        <= next_plane_we;
      end
   end

   // Serializer
   pgw_ser_if sif ();
   assign sif.load   = ser_load;
   assign sif.shift  = ser_shift;
   assign sif.format = gc_reg[PGW_IDX_MODE][PGW_SHFMT_BIT];
   assign sif.data   = disp_data;
   assign ser_out    = sif.serial;

   pgw_serializer u_ser (
      .sys_clk (sys_clk),
      .reset   (reset),
      .sif     (sif.ser)
   );

   // Checks
   sequence s_cpu_read;
      mem_rd_req;
   endsequence

   sequence s_latch_write;
      do_write && (wmode == PGW_WM_LATCH) && (wmask == PGW_ONES);
   endsequence

   chk_index_select: assert property (
      @(posedge sys_clk) disable iff (reset)
      (data_wr && index_ptr == PGW_IDX_FILL)
      |=> gc_reg[PGW_IDX_FILL] == $past(io_wdata))
      else $error("data port write missed the indexed register");

   chk_we_gating: assert property (
      @(posedge sys_clk) disable iff (reset)
      do_write |=> plane_we == $past(plane_write_enable))
      else $error("plane enables not applied to write");

   chk_no_stray_we: assert property (
      @(posedge sys_clk) disable iff (reset)
      !do_write |=> plane_we == '0)
      else $error("plane write without a write cycle");

   chk_mask_protect: assert property (
      @(posedge sys_clk) disable iff (reset)
      do_write |=> (plane_wdata & ~{PGW_PLANES{$past(wmask)}})
         == ($past(plane_rdata) & ~{PGW_PLANES{$past(wmask)}}))
      else $error("masked bits were modified");

   chk_compare_all: assert property (
      @(posedge sys_clk) disable iff (reset)
      (mem_rd_req && read_cmp && dont_care == '1)
      |=> cpu_rdata == PGW_ONES && cpu_rdata_valid)
      else $error("all don't-care compare must return ones");

   chk_plane_one: assert property (
      @(posedge sys_clk) disable iff (reset)
      (mem_rd_req && !read_cmp && rsel == 3'h1)
      |=> cpu_rdata == $past(plane_rdata[15:8]))
      else $error("read select one did not return plane one");

   chk_no_plane: assert property (
      @(posedge sys_clk) disable iff (reset)
      (mem_rd_req && !read_cmp && rsel[PGW_RSEL_NONE])
      |=> cpu_rdata == PGW_ZEROS)
      else $error("read select bit two still returned a plane");

   chk_expand_mode: assert property (
      @(posedge sys_clk) disable iff (reset)
      (do_write && wmode == PGW_WM_EXPAND && func_sel == PGW_FN_REPLACE)
      |=> (plane_wdata[7:0] & $past(wmask))
          == ({PGW_BYTE_W{$past(cpu_wdata[0])}} & $past(wmask)))
      else $error("write mode two did not expand data bit");

   chk_latch_copy: assert property (
      @(posedge sys_clk) disable iff (reset)
      s_cpu_read ##1 s_latch_write |=> plane_wdata == $past(plane_rdata, 2))
      else $error("write mode one did not store latched data");

   chk_reset_clear: assert property (
      @(posedge sys_clk)
      $fell(reset) |-> gc_reg[PGW_IDX_MODE] == PGW_REG_RESET
                       && gc_reg[PGW_IDX_ROT] == PGW_REG_RESET)
      else $error("registers not cleared by reset");
endmodule
`default_nettype wire

// File: sim/pgw_mem_model.sv
// Display memory model: one location holding four plane bytes
`timescale 1ns/10ps
`default_nettype none
module pgw_mem_model
   import pgw_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  preload,
   input  wire logic [PGW_BUS_W-1:0]  preload_data,
   input  wire logic [PGW_BUS_W-1:0]  plane_wdata,
   input  wire logic [PGW_PLANES-1:0] plane_we,
   output logic [PGW_BUS_W-1:0]       plane_rdata
);
   logic [PGW_BUS_W-1:0] store = 32'h00000000;

   // Contents show at once, as the datapath expects
   assign plane_rdata = store;

   always @(posedge sys_clk) begin
      if (preload) begin
         store <= preload_data;
      end else begin
         for (int p = 0; p < PGW_PLANES; p++) begin
            if (plane_we[p]) begin
               store[8*p +: 8] <= plane_wdata[8*p +: 8];
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/pgw_graphics_datapath_tb.sv
// Self-checking bench of the planar graphics datapath
`timescale 1ns/10ps
`default_nettype none
module pgw_graphics_datapath_tb;
   import pgw_pkg::*;
   logic                  sys_clk = 1'b0;
   logic                  reset = 1'b1;
   logic [15:0]           io_addr = 16'h0000;
   logic                  io_wr = 1'b0;
   logic [7:0]            io_wdata = 8'h00;
   logic                  mem_rd_req = 1'b0;
   logic                  mem_wr_req = 1'b0;
   logic [7:0]            cpu_wdata = 8'h00;
   logic [PGW_BUS_W-1:0]  plane_rdata;
   logic [PGW_PLANES-1:0] plane_write_enable = 4'hF;
   logic                  ser_load = 1'b0;
   logic                  ser_shift = 1'b0;
   logic [PGW_BUS_W-1:0]  disp_data = 32'h96C35AE1;
   logic [7:0]            cpu_rdata;
   logic                  cpu_rdata_valid;
   logic [PGW_BUS_W-1:0]  plane_wdata;
   logic [PGW_PLANES-1:0] plane_we;
   logic [PGW_PLANES-1:0] ser_out;
   logic                  preload = 1'b0;
   logic [PGW_BUS_W-1:0]  preload_data = 32'h00000000;
   logic [PGW_BUS_W-1:0]  latch;
   logic [7:0]            rd;
   int                    fails = 0;
   int                    samples_checked = 0;

   always #2.5 sys_clk = ~sys_clk;

   pgw_graphics_datapath u_pgw_graphics_datapath (
      .sys_clk(sys_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
      .io_wdata(io_wdata), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
      .cpu_wdata(cpu_wdata), .plane_rdata(plane_rdata),
      .plane_write_enable(plane_write_enable), .ser_load(ser_load),
      .ser_shift(ser_shift), .disp_data(disp_data), .cpu_rdata(cpu_rdata),
      .cpu_rdata_valid(cpu_rdata_valid), .plane_wdata(plane_wdata),
      .plane_we(plane_we), .ser_out(ser_out));

   pgw_mem_model u_pgw_mem_model (
      .sys_clk(sys_clk), .preload(preload), .preload_data(preload_data),
      .plane_wdata(plane_wdata), .plane_we(plane_we),
      .plane_rdata(plane_rdata));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h",
                  $time, what, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Counts: %0d checked, %0d failed", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge sys_clk);
      io_wr = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic reg_write(input logic [3:0] idx, input logic [7:0] v);
      io_write(PGW_INDEX_PORT, {4'h0, idx});
      io_write(PGW_DATA_PORT, v);
   endtask

   task automatic pre(input logic [31:0] d);
      preload_data = d;
      preload = 1'b1;
      @(negedge sys_clk);
      preload = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic mem_read(output logic [7:0] d);
      int n;
      mem_rd_req = 1'b1;
      latch = plane_rdata;
      @(negedge sys_clk);
      mem_rd_req = 1'b0;
      n = 0;
      while (cpu_rdata_valid !== 1'b1 && n < 4) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 4) begin
         fails++;
         close_out();
      end
      d = cpu_rdata;
      @(negedge sys_clk);
   endtask

   task automatic mem_write(input logic [7:0] d);
      cpu_wdata = d;
      mem_wr_req = 1'b1;
      @(negedge sys_clk);
      mem_wr_req = 1'b0;
      check(plane_we, plane_write_enable, "plane strobes");
      @(negedge sys_clk);
   endtask

   function automatic logic [7:0] rotr(input logic [7:0] d,
                                       input logic [2:0] n);
      logic [15:0] t;
      t = {d, d} >> n;
      return t[7:0];
   endfunction

   function automatic logic [7:0] alu(input logic [1:0] fn,
                                      input logic [7:0] d,
                                      input logic [7:0] l);
      case (fn)
         2'h0: return d;
         2'h1: return d & l;
         2'h2: return d | l;
         default: return d ^ l;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] val, input logic [31:0] bm,
      input logic [3:0] pwe, input logic [7:0] wm);
      logic [31:0] r;
      logic [7:0]  m;
      r = old;
      for (int p = 0; p < 4; p++) begin
         m = bm[8*p +: 8] & wm;
         if (pwe[p]) begin
            r[8*p +: 8] = (val[8*p +: 8] & m) | (old[8*p +: 8] & ~m);
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] cmpexp(input logic [31:0] mv,
      input logic [3:0] c, input logic [3:0] dc);
      logic [7:0] r;
      r = 8'hFF;
      for (int b = 0; b < 8; b++) begin
         for (int p = 0; p < 4; p++) begin
            if (!dc[p] && mv[8*p+b] != c[p]) begin
               r[b] = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] lane(input logic f, input int p,
                                       input logic [31:0] dd);
      logic [7:0] a;
      logic [7:0] b;
      int         s;
      a = dd[8*(p & 2) +: 8];
      b = dd[8*(p & 2) + 8 +: 8];
      s = p & 1;
      if (!f) begin
         return dd[8*p +: 8];
      end
      return {a[6+s], a[4+s], a[2+s], a[s], b[6+s], b[4+s], b[2+s], b[s]};
   endfunction

   task automatic t_reset;
      check(cpu_rdata, 8'h00, "read data at reset");
      check(plane_we, 4'h0, "strobes at reset");
      pre(32'h12345678);
      mem_write(8'hFF);
      check(plane_rdata, 32'h12345678, "mask zero");
      mem_read(rd);
      check(rd, 8'h78, "default plane read");
      $display("test reset done");
   endtask

   task automatic t_fill;
      logic [7:0]  r;
      logic [31:0] e;
      reg_write(PGW_IDX_WMASK, 8'hF7);
      reg_write(PGW_IDX_FILL, 8'h0B);
      reg_write(PGW_IDX_FILL_EN, 8'h05);
      reg_write(PGW_IDX_ROT, 8'h03);
      plane_write_enable = 4'hB;
      pre(32'h5A5A5A5A);
      r = rotr(8'hA1, 3'h3);
      e = merge(32'h5A5A5A5A, {r, 8'h00, r, 8'hFF}, {8'hFF, r, 8'hFF, r},
                4'hB, 8'hF7);
      mem_write(8'hA1);
      check(plane_rdata[15:0], e[15:0], "fill lo");
      check(plane_rdata[31:16], e[31:16], "fill hi");
      plane_write_enable = 4'hF;
      $display("test fill done");
   endtask

   task automatic t_logic;
      logic [31:0] e;
      reg_write(PGW_IDX_FILL_EN, 8'h00);
      reg_write(PGW_IDX_WMASK, 8'hFF);
      for (int fn = 0; fn < 4; fn++) begin
         reg_write(PGW_IDX_ROT, {3'h0, 2'(fn), 3'h2});
         pre(32'hC3A50FF0);
         mem_read(rd);
         pre(32'h3C3C3C3C);
         mem_write(8'h96);
         for (int p = 0; p < 4; p++) begin
            e[8*p +: 8] = alu(2'(fn), rotr(8'h96, 3'h2), latch[8*p +: 8]);
         end
         check(plane_rdata, e, "logic op");
      end
      reg_write(PGW_IDX_ROT, 8'h00);
      $display("test logic done");
   endtask

   task automatic t_modes;
      logic [31:0] e;
      pre(32'h11223344);
      mem_read(rd);
      pre(32'hAABBCCDD);
      reg_write(PGW_IDX_MODE, 8'h01);
      mem_write(8'h00);
      check(plane_rdata, 32'h11223344, "latch write");
      // Read then write back to back while memory changes under the latch
      mem_rd_req = 1'b1;
      preload_data = 32'hAABBCCDD;
      preload = 1'b1;
      @(negedge sys_clk);
      mem_rd_req = 1'b0;
      preload = 1'b0;
      mem_wr_req = 1'b1;
      @(negedge sys_clk);
      mem_wr_req = 1'b0;
      @(negedge sys_clk);
      check(plane_rdata, 32'h11223344, "read then write");
      reg_write(PGW_IDX_MODE, 8'h02);
      reg_write(PGW_IDX_WMASK, 8'h0F);
      e = merge(32'h11223344, 32'h00FF00FF, 32'hFFFFFFFF, 4'hF, 8'h0F);
      mem_write(8'hA5);
      check(plane_rdata, e, "expand write");
      reg_write(PGW_IDX_MODE, 8'h00);
      reg_write(PGW_IDX_WMASK, 8'hFF);
      $display("test modes done");
   endtask

   task automatic t_read;
      pre(32'h44332211);
      for (int s = 0; s < 4; s++) begin
         reg_write(PGW_IDX_RSEL, 8'(s));
         mem_read(rd);
         check(rd, 8'h11 * (s + 1), "plane read");
      end
      io_write(16'h03CD, 8'h00);
      mem_read(rd);
      check(rd, 8'h44, "stray port ignored");
      reg_write(PGW_IDX_RSEL, 8'h04);
      mem_read(rd);
      check(rd, 8'h00, "no plane read");
      reg_write(PGW_IDX_RSEL, 8'h00);
      $display("test read done");
   endtask

   task automatic t_cmp;
      logic [3:0] dc;
      logic [7:0] ex;
      pre(32'hF0A15EA1);
      reg_write(PGW_IDX_CMP, 8'h0B);
      reg_write(PGW_IDX_MODE, 8'h08);
      for (int k = 0; k < 3; k++) begin
         dc = (k == 2) ? 4'hF : ((k == 1) ? 4'h8 : 4'h0);
         reg_write(PGW_IDX_DCARE, {4'h0, dc});
         ex = cmpexp(32'hF0A15EA1, 4'hB, dc);
         mem_read(rd);
         check(rd, ex, "compare read");
      end
      reg_write(PGW_IDX_DCARE, 8'h00);
      reg_write(PGW_IDX_MODE, 8'h00);
      $display("test compare done");
   endtask

   task automatic t_ser;
      logic [3:0] e;
      logic [7:0] w;
      for (int f = 0; f < 2; f++) begin
         reg_write(PGW_IDX_MODE, f ? 8'h20 : 8'h00);
         ser_load = 1'b1;
         @(negedge sys_clk);
         ser_load = 1'b0;
         ser_shift = 1'b1;
         for (int i = 0; i < 8; i++) begin
            for (int p = 0; p < 4; p++) begin
               w = lane(f[0], p, disp_data);
               e[p] = w[7-i];
            end
            check(ser_out, e, "serial bits");
            @(negedge sys_clk);
         end
         ser_shift = 1'b0;
      end
      reg_write(PGW_IDX_MODE, 8'h00);
      $display("test serializer done");
   endtask

   initial begin
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_fill();
      t_logic();
      t_modes();
      t_read();
      t_cmp();
      t_ser();
      close_out();
   end
endmodule
`default_nettype wire
